// [core/xmpc_pkg.sv]
// Package of constants and types for the external memory pin-control block.
// Functional notes
// - Reset straps pick interface input clock source.
// - Default strap selects external input clock.
// - Divided output clock: input over 1, 2, 4.
// - Full rate output clock equals input clock.
// - Sync strobe: address strobe or read enable.
// - Read pin muxed by memory type.
// - Output-enable pin muxed by memory type.
// - Write pin same for all memory types.
// - SDRAM clock enable, else general output.
// - Dedicated FIFO output enable for space 3.
// - Host hold request answered by hold acknowledge.
// - Bus request output when bus needed.
// - Ready input paces asynchronous accesses.
// - Peripheral direct transfer output driven.
// - One chip enable from address bits 28-29.
// - Byte enables from low address, width dependent.
package xmpc_pkg;
    localparam logic [1:0] XMPC_STRAP_EXT  = 2'h0;
    localparam logic [1:0] XMPC_STRAP_DIV4 = 2'h1;
    localparam logic [1:0] XMPC_STRAP_DIV6 = 2'h2;
    localparam logic [1:0] XMPC_DIV_1      = 2'h0;
    localparam logic [1:0] XMPC_DIV_2      = 2'h1;
    localparam logic [1:0] XMPC_DIV_4      = 2'h2;
    localparam logic [1:0] XMPC_W_8        = 2'h0;
    localparam logic [1:0] XMPC_W_16       = 2'h1;
    localparam logic [1:0] XMPC_W_32       = 2'h2;
    localparam logic [1:0] XMPC_W_64       = 2'h3;
    localparam int         XMPC_CE_LSB     = 28;
    localparam int         XMPC_FIFO_CE    = 3;
    localparam int         XMPC_RDY_TMO_NS = 2000;
    localparam int         XMPC_CLK_NS     = 50;
    localparam int         XMPC_RDY_TMO_CYC = XMPC_RDY_TMO_NS / XMPC_CLK_NS;
    localparam int         XMPC_RDY_SYNC_CYC = 4;
    localparam logic [3:0] XMPC_STROBES_IDLE = 4'h0;

    typedef enum logic [1:0]
    {
        XMPC_MEM_ASYNC = 2'b00,
        XMPC_MEM_SDRAM = 2'b01,
        XMPC_MEM_SYNC  = 2'b10
    } xmpc_mem_t;

    typedef enum logic [2:0]
    {
        XMPC_IDLE   = 3'b000,
        XMPC_ACCESS = 3'b001,
        XMPC_WAITRD = 3'b010,
        XMPC_RELEAS = 3'b011,
        XMPC_HELD   = 3'b100
    } xmpc_state_t;

    // Strobe commands for one access cycle, active high inside the block.
    typedef struct packed
    {
        logic rd;
        logic oe;
        logic wr;
        logic cke;
    } xmpc_strobe_t;

    // Pin levels that go to the pad ring, active low where the pin is.
    typedef struct packed
    {
        logic         rd_n;
        logic         oe_n;
        logic         we_n;
        logic         fifo_oe_n;
        logic [3:0]   ce_n;
        logic [7:0]   be_n;
        logic         pdt_n;
        logic         cke;
    } xmpc_pins_t;
endpackage

// [core/xmpc_clkgen.sv]
// Interface clock source selection and output clock dividers.
`timescale 1ns/1ns
module xmpc_clkgen
    import xmpc_pkg::*;
(
    input  wire logic       ref_clk,       // Core clock.
    input  wire logic       sys_rst,       // Asynchronous reset, active high.
    input  wire logic       strap_load,    // Pulse after reset to capture straps.
    input  wire logic [1:0] straps,        // Synchronised strap levels.
    input  wire logic       ext_tick,      // Synchronised external clock edge, either way.
    input  wire logic [1:0] div_sel,       // Divider for the second output clock.
    output logic            full_rate_out, // Full rate output clock.
    output logic            divided_out    // Divided output clock.
);
    logic [1:0] src_sel;
    logic [2:0] cpu_cnt;
    logic [1:0] div_cnt;
    logic       tick;
    wire        cnt_wrap;
    wire  [2:0] cnt_max;

    assign cnt_max  = (src_sel == XMPC_STRAP_DIV6) ? 3'h2 : 3'h1;
    assign cnt_wrap = (cpu_cnt == cnt_max);

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            src_sel <= XMPC_STRAP_EXT;
        else if (strap_load)
            src_sel <= (straps == XMPC_STRAP_DIV4 || straps == XMPC_STRAP_DIV6)
                       ? straps : XMPC_STRAP_EXT;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            cpu_cnt <= 3'h0;
        else
            cpu_cnt <= cnt_wrap ? 3'h0 : cpu_cnt + 3'h1;
    end

    // Each half period of the interface clock is marked by tick; the full rate clock toggles on every tick, the divided clock on every 1st, 2nd or 4th.
    always_comb
    begin
        tick = (src_sel == XMPC_STRAP_EXT) ? ext_tick : cnt_wrap;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            full_rate_out <= 1'b0;
            divided_out   <= 1'b0;
            div_cnt       <= 2'h0;
        end
        else if (tick)
        begin
            full_rate_out <= ~full_rate_out;
            div_cnt       <= div_cnt + 2'h1;
            case (div_sel)
                XMPC_DIV_1: divided_out <= ~divided_out;
                XMPC_DIV_2: divided_out <= div_cnt[0] ? ~divided_out : divided_out;
                XMPC_DIV_4: divided_out <= (div_cnt == 2'h3) ? ~divided_out : divided_out;
                default:    divided_out <= ~divided_out;
            endcase
        end
    end
endmodule

// [core/xmpc_top.sv]
// Pin control for the wide external memory interface.
`timescale 1ns/1ns
module xmpc_top
    import xmpc_pkg::*;
#(
    parameter int RDY_TMO = XMPC_RDY_TMO_CYC
)
(
    input  wire logic        ref_clk,                    // Core clock, 20 MHz.
    input  wire logic        sys_rst,                    // Asynchronous reset, active high.
    input  wire logic        ext_input_clock,            // External interface clock pin.
    input  wire logic [1:0]  clock_select_straps,        // Clock source straps.
    input  wire logic [1:0]  div_sel,                    // Divided clock factor code.
    input  wire logic        read_enable_mode_sel,       // Sync strobe mode.
    input  wire logic        acc_req,                    // Core access request.
    input  wire logic        acc_write,                  // Request is a write.
    input  wire logic [31:0] acc_addr,                   // Byte address of request.
    input  wire logic [1:0]  acc_width,                  // External memory width code.
    input  wire xmpc_mem_t   acc_mem,                    // Memory type of the space.
    input  wire logic        acc_pdt,                    // Peripheral direct transfer.
    input  wire logic        self_refresh,               // Drop clock enable.
    input  wire logic        gp_out,                     // General output when no SDRAM.
    input  wire logic        sdram_fitted,               // SDRAM present.
    input  wire logic        async_ready_in,             // Ready pin.
    input  wire logic        bus_hold_request,           // Host hold request pin.
    output logic             acc_done,                   // Access complete pulse.
    output logic             full_rate_output_clock,     // Full rate clock.
    output logic             divided_output_clock,       // Divided clock.
    output xmpc_pins_t       pins,                       // Control pin levels.
    output logic             pins_oe,                    // Control pins driven.
    output logic             bus_hold_ack,               // Hold acknowledge.
    output logic             bus_need_out                // Bus request output.
);
    xmpc_state_t state;
    xmpc_state_t next_state;
    logic [2:0]  rdy_sync;
    logic [2:0]  hold_sync;
    logic [2:0]  eclk_sync;
    logic [2:0]  strap_sync0;
    logic [2:0]  strap_sync1;
    logic        rdy_st;
    logic        hold_st;
    logic        eclk_st;
    logic        strap_done;
    logic [1:0]  strap_age;
    logic [15:0] wait_cnt;
    logic        req_w;
    logic [31:0] req_a;
    logic [1:0]  req_wd;
    xmpc_mem_t   req_m;
    logic        req_pdt;
    logic        full_rate_int;
    logic        divided_int;
    xmpc_strobe_t stb;
    xmpc_pins_t  next_pins;

    function automatic logic [7:0] be_decode(input logic [2:0] a, input logic [1:0] w);
        logic [7:0] m;
        m = 8'h00;
        case (w)
            XMPC_W_8:  m = 8'h01 << a[1:0];
            XMPC_W_16: m = 8'h03 << {a[1], 1'b0};
            XMPC_W_32: m = 8'h0F;
            XMPC_W_64: m = 8'hFF;
            default:   m = 8'hFF;
        endcase
        return m;
    endfunction

    function automatic logic [3:0] ce_decode(input logic [3:0] region);
        return 4'h1 << region[1:0];
    endfunction

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdy_sync    <= 3'h0;
            hold_sync   <= 3'h0;
            eclk_sync   <= 3'h0;
            strap_sync0 <= 3'h0;
            strap_sync1 <= 3'h0;
        end
        else
        begin
            rdy_sync    <= {rdy_sync[1:0], async_ready_in};
            hold_sync   <= {hold_sync[1:0], bus_hold_request};
            eclk_sync   <= {eclk_sync[1:0], ext_input_clock};
            strap_sync0 <= {strap_sync0[1:0], clock_select_straps[0]};
            strap_sync1 <= {strap_sync1[1:0], clock_select_straps[1]};
        end
    end

    // Filtered levels change only when stages two and three agree.
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdy_st  <= 1'b0;
            hold_st <= 1'b0;
            eclk_st <= 1'b0;
        end
        else
        begin
            rdy_st  <= (rdy_sync[1] == rdy_sync[2]) ? rdy_sync[2] : rdy_st;
            hold_st <= (hold_sync[1] == hold_sync[2]) ? hold_sync[2] : hold_st;
            eclk_st <= (eclk_sync[1] == eclk_sync[2]) ? eclk_sync[2] : eclk_st;
        end
    end

    wire eclk_edge  = (eclk_sync[1] == eclk_sync[2]) & (eclk_sync[2] != eclk_st);
    wire strap_ok   = (strap_sync0[1] == strap_sync0[2]) & (strap_sync1[1] == strap_sync1[2]);
    // Straps are taken only once all three stages hold pin levels, not reset values.
    wire strap_load = ~strap_done & strap_ok & (strap_age == 2'h3);

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            strap_done <= 1'b0;
            strap_age  <= 2'h0;
        end
        else
        begin
            strap_age <= (strap_age == 2'h3) ? strap_age : strap_age + 2'h1;
            if (strap_load)
                strap_done <= 1'b1;
        end
    end

    xmpc_clkgen u_clkgen
    (
        .ref_clk       (ref_clk),
        .sys_rst       (sys_rst),
        .strap_load    (strap_load),
        .straps        ({strap_sync1[2], strap_sync0[2]}),
        .ext_tick      (eclk_edge),
        .div_sel       (div_sel),
        .full_rate_out (full_rate_int),
        .divided_out   (divided_int)
    );

    wire start    = (state == XMPC_IDLE) & acc_req & ~hold_st & strap_done;
    wire async_rd = (req_m == XMPC_MEM_ASYNC);
    wire tmo      = (wait_cnt == RDY_TMO[15:0]);
    // Ready is trusted only once the synchroniser shows the level seen under the strobes.
    wire rdy_valid = (wait_cnt >= XMPC_RDY_SYNC_CYC[15:0]);

    always_comb
    begin
        next_state = state;
        case (state)
            XMPC_IDLE:
                if (hold_st)
                    next_state = XMPC_RELEAS;
                else if (start)
                    next_state = XMPC_ACCESS;
            XMPC_ACCESS:
                next_state = async_rd ? XMPC_WAITRD : XMPC_IDLE;
            XMPC_WAITRD:
                if ((rdy_st & rdy_valid) | tmo)
                    next_state = XMPC_IDLE;
            XMPC_RELEAS:
                next_state = XMPC_HELD;
            XMPC_HELD:
                if (!hold_st)
                    next_state = XMPC_IDLE;
            default:
                next_state = XMPC_IDLE;
        endcase
    end

    wire active = (state == XMPC_ACCESS) | (state == XMPC_WAITRD);

    // Per memory type the read and output-enable pins carry different strobes; the write pin carries the write strobe in all types.
    always_comb
    begin
        stb     = XMPC_STROBES_IDLE;
        stb.cke = sdram_fitted ? ~self_refresh : gp_out;
        if (active)
        begin
            case (req_m)
                XMPC_MEM_ASYNC:
                begin
                    stb.rd = ~req_w;
                    stb.oe = ~req_w;
                    stb.wr = req_w;
                end
                XMPC_MEM_SDRAM:
                begin
                    stb.rd = 1'b1;
                    stb.oe = 1'b0;
                    stb.wr = req_w;
                end
                XMPC_MEM_SYNC:
                begin
                    stb.rd = read_enable_mode_sel ? ~req_w : 1'b1;
                    stb.oe = ~req_w;
                    stb.wr = req_w;
                end
                default:
                    stb.rd = 1'b0;
            endcase
        end
    end

    always_comb
    begin
        next_pins.rd_n      = ~stb.rd;
        next_pins.oe_n      = ~stb.oe;
        next_pins.we_n      = ~stb.wr;
        next_pins.cke       = stb.cke;
        next_pins.ce_n      = active ? ~ce_decode(req_a[31:28]) : 4'hF;
        next_pins.be_n      = active ? ~be_decode(req_a[2:0], req_wd) : 8'hFF;
        next_pins.fifo_oe_n = ~(active & stb.oe & (req_a[29:28] == XMPC_FIFO_CE[1:0])
                              & (req_m == XMPC_MEM_SYNC));
        next_pins.pdt_n     = ~(active & req_pdt);
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state    <= XMPC_IDLE;
            wait_cnt <= 16'h0000;
            req_w    <= 1'b0;
            req_a    <= 32'h0000_0000;
            req_wd   <= XMPC_W_64;
            req_m    <= XMPC_MEM_ASYNC;
            req_pdt  <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            wait_cnt <= (state == XMPC_WAITRD) ? wait_cnt + 16'h0001 : 16'h0000;
            if (start)
            begin
                req_w   <= acc_write;
                req_a   <= acc_addr;
                req_wd  <= acc_width;
                req_m   <= acc_mem;
                req_pdt <= acc_pdt;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pins                   <= '1;
            pins_oe                <= 1'b0;
            bus_hold_ack           <= 1'b0;
            bus_need_out           <= 1'b0;
            acc_done               <= 1'b0;
            full_rate_output_clock <= 1'b0;
            divided_output_clock   <= 1'b0;
        end
        else
        begin
            pins                   <= next_pins;
            pins_oe                <= (next_state != XMPC_RELEAS) & (next_state != XMPC_HELD);
            bus_hold_ack           <= (next_state == XMPC_HELD);
            bus_need_out           <= acc_req & (hold_st | (state == XMPC_HELD));
            acc_done               <= (state != XMPC_IDLE) & (next_state == XMPC_IDLE)
                                      & (state != XMPC_HELD);
            full_rate_output_clock <= full_rate_int;
            divided_output_clock   <= divided_int;
        end
    end
endmodule

// [tb/xmpc_monitor.sv]
// Concurrent checks on the ports of the pin-control top module.
`timescale 1ns/1ns
module xmpc_monitor
    import xmpc_pkg::*;
#(
    parameter int RDY_TMO = 8
)
(
    input wire logic       ref_clk,          // Clock.
    input wire logic       sys_rst,          // Reset.
    input wire logic       sdram_fitted,     // SDRAM present.
    input wire logic       self_refresh,     // Self-refresh request.
    input wire logic       gp_out,           // General output level.
    input wire logic       acc_req,          // Access request.
    input wire logic       bus_hold_request, // Host hold request.
    input wire logic       acc_done,         // Access complete.
    input wire xmpc_pins_t pins,             // Control pins.
    input wire logic       pins_oe,          // Pins driven.
    input wire logic       bus_hold_ack,     // Hold acknowledge.
    input wire logic       bus_need_out      // Bus request.
);
    localparam int DONE_MAX  = RDY_TMO + 12;
    localparam int GRANT_MAX = RDY_TMO + 16;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_hold_asked;
        $rose(bus_hold_request);
    endsequence

    sequence s_access_taken;
        $rose(acc_req) && !bus_hold_request && !bus_hold_ack;
    endsequence

    property p_grant;
        s_hold_asked |-> ##[1:GRANT_MAX] (bus_hold_ack || !bus_hold_request);
    endproperty

    chk_hold_grant: assert property (p_grant)
        else $error("hold request not answered in time");
    chk_ack_drop: assert property ($fell(bus_hold_request) |-> ##[1:8] !bus_hold_ack)
        else $error("hold acknowledge kept after request dropped");
    chk_ack_released: assert property (bus_hold_ack |-> !pins_oe)
        else $error("pins driven while hold acknowledged");
    chk_release_first: assert property ($rose(bus_hold_ack) |-> !$past(pins_oe))
        else $error("hold acknowledged before pins released");
    chk_done_bound: assert property (s_access_taken |-> ##[2:DONE_MAX] acc_done)
        else $error("access not completed in time");
    chk_ce_single: assert property ($countones(pins.ce_n) >= 3)
        else $error("more than one chip enable low");
    chk_fifo_space: assert property (!pins.fifo_oe_n |-> !pins.ce_n[3])
        else $error("fifo output enable outside space 3");
    chk_oe_on_write: assert property (!pins.we_n |-> pins.oe_n)
        else $error("output enable low during write");
    chk_cke_gp: assert property (!sdram_fitted && gp_out |-> ##[1:3] pins.cke)
        else $error("clock enable not following general output");
    chk_self_ref: assert property (sdram_fitted && self_refresh |-> ##[1:3] !pins.cke)
        else $error("clock enable high in self-refresh");
    chk_bus_need: assert property (bus_hold_ack && acc_req |-> ##[0:3] bus_need_out)
        else $error("bus request missing while held");
endmodule

// [tb/xmpc_far_model.sv]
// Behavioural model of the async memory and bus host beyond the pins.
`timescale 1ns/1ns
module xmpc_far_model
    import xmpc_pkg::*;
#(
    parameter int WAIT = 2
)
(
    input  wire logic       ref_clk,         // Clock.
    input  wire logic       sys_rst,         // Reset.
    input  wire xmpc_pins_t pins,            // Control pins.
    input  wire logic       pins_oe,         // Pins driven.
    input  wire logic       stuck,           // Never become ready.
    input  wire logic       hold_cmd,        // Host wants the bus.
    output logic            async_ready_in,  // Ready line.
    output logic            bus_hold_request // Hold request.
);
    logic [3:0] cnt;
    wire        sel = pins_oe && (!pins.rd_n || !pins.we_n);

    always_ff @(posedge ref_clk or posedge sys_rst)
        if (sys_rst)
            cnt <= 4'h0;
        else if (!sel)
            cnt <= 4'h0;
        else if (cnt != 4'hf)
            cnt <= cnt + 4'h1;

    // The line is pulled up when no peripheral is strobed and stuck is low.
    assign async_ready_in   = stuck ? 1'b0 : (!sel || cnt >= WAIT);
    assign bus_hold_request = hold_cmd;
endmodule

// [tb/xmpc_top_tb.sv]
// Self-checking bench for the external memory pin-control block.
`timescale 1ns/1ns
module xmpc_top_tb;
    import xmpc_pkg::*;
    localparam int TMO = 16;
    logic        ref_clk = 0, sys_rst = 1, ext_input_clock = 0;
    logic [1:0]  clock_select_straps = 2'h0, div_sel = 2'h0, acc_width = XMPC_W_32;
    logic        read_enable_mode_sel = 0, acc_req = 0, acc_write = 0, acc_pdt = 0;
    logic        self_refresh = 0, gp_out = 0, sdram_fitted = 0, hold_cmd = 0, stuck = 0;
    logic [31:0] acc_addr = 32'h0;
    xmpc_mem_t   acc_mem = XMPC_MEM_ASYNC;
    logic        async_ready_in, bus_hold_request, acc_done, full_rate_output_clock;
    logic        divided_output_clock, pins_oe, bus_hold_ack, bus_need_out;
    xmpc_pins_t  pins;
    logic [7:0]  be_seen;
    int          fail_count = 0, checked = 0, cyc = 0;

    xmpc_top #(.RDY_TMO(TMO)) DUT (.ref_clk, .sys_rst, .ext_input_clock, .clock_select_straps,
        .div_sel, .read_enable_mode_sel, .acc_req, .acc_write, .acc_addr, .acc_width, .acc_mem,
        .acc_pdt, .self_refresh, .gp_out, .sdram_fitted, .async_ready_in, .bus_hold_request,
        .acc_done, .full_rate_output_clock, .divided_output_clock, .pins, .pins_oe,
        .bus_hold_ack, .bus_need_out);

    xmpc_far_model FAR (.ref_clk, .sys_rst, .pins, .pins_oe, .stuck, .hold_cmd,
        .async_ready_in, .bus_hold_request);

    always #25 ref_clk = ~ref_clk;
    always #250 ext_input_clock = ~ext_input_clock;

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic tick(int n = 1);
        repeat (n)
        begin
            @(posedge ref_clk);
            #5;
        end
    endtask

    task automatic cmp(logic [31:0] got, logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset(logic [1:0] s);
        sys_rst = 1'b1;
        clock_select_straps = s;
        tick(8);
        sys_rst = 1'b0;
        tick(8);
    endtask

    // Counts core cycles between two rising edges of one output clock.
    task automatic period(logic which, output int n);
        int   t [2];
        int   k, r;
        logic p, c;
        t = '{0, 0};
        k = 0;
        r = 0;
        p = 1'b1;
        while (r < 2 && k < 400)
        begin
            tick();
            k++;
            c = which ? divided_output_clock : full_rate_output_clock;
            if (c && !p)
            begin
                t[r] = k;
                r++;
            end
            p = c;
        end
        n = t[1] - t[0];
    endtask

    task automatic t_clocks();
        int f, d;
        int mul [4] = '{1, 2, 4, 1};
        int src [4] = '{10, 4, 6, 10};
        for (int s = 0; s < 4; s++)
        begin
            do_reset(2'(s));
            for (int v = 0; v < 4; v++)
            begin
                div_sel = 2'(v);
                tick(40);
                period(1'b0, f);
                period(1'b1, d);
                cmp(32'(f), 32'(src[s]));
                cmp(32'(d), 32'(src[s] * mul[v]));
            end
        end
    endtask

    task automatic t_cke();
        logic [2:0] row [4] = '{3'h1, 3'h0, 3'h7, 3'h4};
        logic [3:0] exp = 4'h9;
        for (int i = 0; i < 4; i++)
        begin
            {sdram_fitted, self_refresh, gp_out} = row[i];
            tick(4);
            cmp(32'(pins.cke), 32'(exp[i]));
        end
    endtask

    // Runs one access and gathers which strobes went low on the way.
    task automatic access(xmpc_mem_t m, logic w, logic [31:0] a, output logic [4:0] lo,
                          output logic [3:0] ce, output int lat);
        acc_mem = m;
        acc_write = w;
        acc_addr = a;
        acc_req = 1'b1;
        lo = 5'h0;
        ce = 4'h0;
        lat = 0;
        be_seen = 8'h00;
        while (acc_done !== 1'b1 && lat < 60)
        begin
            tick();
            lat++;
            lo |= ~{pins.rd_n, pins.oe_n, pins.we_n, pins.fifo_oe_n, pins.pdt_n};
            ce |= ~pins.ce_n;
            be_seen |= ~pins.be_n;
        end
        acc_req = 1'b0;
        tick();
    endtask

    task automatic t_types();
        xmpc_mem_t  mt [8] = '{XMPC_MEM_ASYNC, XMPC_MEM_ASYNC, XMPC_MEM_SDRAM, XMPC_MEM_SDRAM,
                               XMPC_MEM_SYNC, XMPC_MEM_SYNC, XMPC_MEM_SYNC, XMPC_MEM_SYNC};
        logic [7:0] wr = 8'h6a;
        logic [7:0] md = 8'h30;
        logic [1:0] sp [8] = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h3, 2'h3, 2'h0, 2'h0};
        logic [4:0] mk [8] = '{5'h1f, 5'h1f, 5'h14, 5'h14, 5'h1f, 5'h1f, 5'h16, 5'h12};
        logic [4:0] ex [8] = '{5'h19, 5'h04, 5'h10, 5'h14, 5'h1a, 5'h04, 5'h14, 5'h10};
        logic [4:0] lo;
        logic [3:0] ce;
        int         lat;
        sdram_fitted = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            read_enable_mode_sel = md[i];
            acc_pdt = (i == 0);
            access(mt[i], wr[i], {2'h0, sp[i], 28'h000_0000}, lo, ce, lat);
            cmp(32'(lo & mk[i]), 32'(ex[i]));
            cmp(32'(ce), 32'h1 << sp[i]);
            if (i < 2)
                cmp(32'(lat < TMO), 32'h1);
        end
        stuck = 1'b1;
        access(XMPC_MEM_ASYNC, 1'b0, 32'h0, lo, ce, lat);
        cmp(32'(lat >= TMO), 32'h1);
        stuck = 1'b0;
    endtask

    task automatic t_hold();
        int k;
        hold_cmd = 1'b1;
        for (k = 0; k < 40 && bus_hold_ack !== 1'b1; k++)
            tick();
        cmp(32'({bus_hold_ack, pins_oe}), 32'h2);
        acc_mem = XMPC_MEM_SYNC;
        acc_write = 1'b0;
        acc_req = 1'b1;
        tick(6);
        cmp(32'({bus_need_out, acc_done, pins_oe}), 32'h4);
        hold_cmd = 1'b0;
        for (k = 0; k < 40 && acc_done !== 1'b1; k++)
            tick();
        cmp(32'({bus_hold_ack, acc_done}), 32'h1);
        acc_req = 1'b0;
        tick();
    endtask

    // Byte lanes of one read at byte offset 2 for three memory widths.
    task automatic t_bytes();
        logic [1:0] wd [3] = '{XMPC_W_8, XMPC_W_32, XMPC_W_64};
        logic [7:0] ex [3] = '{8'h04, 8'h0f, 8'hff};
        logic [4:0] lo;
        logic [3:0] ce;
        int         lat;
        for (int i = 0; i < 3; i++)
        begin
            acc_width = wd[i];
            access(XMPC_MEM_SYNC, 1'b0, 32'h0000_0002, lo, ce, lat);
            cmp(32'(be_seen), 32'(ex[i]));
        end
    endtask

    initial
    begin
        t_clocks();
        t_cke();
        t_types();
        t_bytes();
        t_hold();
        test_done();
    end
endmodule

bind xmpc_top xmpc_monitor #(.RDY_TMO(RDY_TMO)) MON (.ref_clk, .sys_rst, .sdram_fitted,
    .self_refresh, .gp_out, .acc_req, .bus_hold_request, .acc_done, .pins, .pins_oe,
    .bus_hold_ack, .bus_need_out);
